//--- hw/ocpwm_top.sv
// Purpose: PWM mode of an output compare channel with its own 16-bit time base.
// Assumes: Timer prescaler ticks and sync events come from logic on clk_i.
// Notes: Fault pins and comparators are asynchronous and pass the syncer first.
`timescale 1ns/1ps

// Notes on behaviour
// - Edge or center aligned PWM; duty values pass hidden shadow registers.
// - Sync code all ones with trigger bit clear syncs counter to itself.
// - Selected timer's prescaler tick, not its overflow, clocks the counter.
// - Period value N gives N plus one time base counts per period.
// - Compare writes any time; shadows load at count equals period, and follow the compares while the channel is off.
// - Both compares and period zero keeps the output low.
// - Secondary compare above period keeps the output high.
// - Idle bit set halts the channel in Idle; clear keeps it running.
// - Time base select picks peripheral clock or one of five timers.
// - Comparator fault enable admits comparator fault; clear ignores it.
// - Pin B fault enable admits pin B fault; clear ignores it.
// - Pin A fault enable admits pin A fault; clear ignores it.
// - Comparator fault status set by hardware, cleared by hardware or software.
// - Pin B fault status set by hardware, cleared by hardware or software.
// - Fault enables and status act only in the two PWM modes.
// - Channel group picks comparator one, two or three as fault source.
// - Mode 111 center aligned, 110 edge aligned, 000 disabled.
// - Pin A fault status set by hardware, cleared by hardware or software.
// - Fault exit: latched until software clear, or at next period start.
// - During a fault the output takes the fault drive level.
module ocpwm_top #(
	parameter int unsigned CHANNEL_NUM = 1
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic [ocpwm_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [ocpwm_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [ocpwm_pkg::DATA_W-1:0] reg_rdata_o,
	input wire logic [ocpwm_pkg::NUM_TIMERS-1:0] timer_tick_i,
	input wire logic idle_mode_i,
	input wire logic sync_event_i,
	input wire logic fault_pin_a_i,
	input wire logic fault_pin_b_i,
	input wire logic [2:0] comparator_out_i,
	output logic compare_output_pin_o
);
	import ocpwm_pkg::*;

	typedef struct packed {
		logic idle_halt_bit;
		logic [2:0] time_base_select;
		logic comparator_fault_enable;
		logic pin_b_fault_enable;
		logic pin_a_fault_enable;
		logic comparator_fault_status;
		logic pin_b_fault_status;
		logic pin_a_fault_status;
		logic trigger_clear_select;
		logic [2:0] channel_mode_field;
		logic fault_exit_select;
		logic fault_drive_level;
		logic trigger_versus_sync_bit;
		logic [4:0] sync_source_select;
		logic [DATA_W-1:0] primary_compare_reg;
		logic [DATA_W-1:0] secondary_compare_reg;
		logic [DATA_W-1:0] timer_period_reg;
		logic [DATA_W-1:0] channel_counter;
		logic [DATA_W-1:0] pcmp_active;
		logic [DATA_W-1:0] scmp_active;
		ocpwm_run_t run;
		logic out;
		logic [DATA_W-1:0] rdata;
	} ocpwm_state_t;

	ocpwm_state_t st_reg;
	ocpwm_state_t st_next;
	ocpwm_fault_if flt ();

	// ==========================================================
	// Helper functions
	function automatic logic is_pwm(input logic [2:0] mode);
		is_pwm = (mode == MODE_EDGE) || (mode == MODE_CENTER);
	endfunction

	// Channels are grouped in threes per comparator
	function automatic logic [1:0] cmp_index(input int unsigned chan);
		cmp_index = (chan <= 3) ? 2'h0 : (chan <= 6) ? 2'h1 : 2'h2;
	endfunction

	// Reserved codes give no tick, so the counter stands
	function automatic logic tick_select(input logic [2:0] tsel,
		input logic [NUM_TIMERS-1:0] ticks);
		unique case (tsel)
			TSEL_PCLK: tick_select = 1'b1;
			TSEL_T1: tick_select = ticks[0];
			TSEL_T2: tick_select = ticks[1];
			TSEL_T3: tick_select = ticks[2];
			TSEL_T4: tick_select = ticks[3];
			TSEL_T5: tick_select = ticks[4];
			default: tick_select = 1'b0;
		endcase
	endfunction

	// ==========================================================
	// Fault source synchronisers
	assign flt.pin_a_raw = fault_pin_a_i;
	assign flt.pin_b_raw = fault_pin_b_i;
	assign flt.cmp_raw = comparator_out_i[cmp_index(CHANNEL_NUM)];

	ocpwm_fault_sync u_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.flt(flt.syncer)
	);

	// ==========================================================
	// Decoded conditions
	logic pwm;
	logic tick;
	logic self_sync;
	logic at_period;
	logic boundary;
	logic fault_on;
	logic level;

	assign pwm = is_pwm(st_reg.channel_mode_field);
	// Idle only halts when the halt bit asks for it
	assign tick = tick_select(st_reg.time_base_select, timer_tick_i)
		&& !(idle_mode_i && st_reg.idle_halt_bit);
	assign self_sync = (st_reg.sync_source_select == SYNC_SELF)
		&& !st_reg.trigger_versus_sync_bit;
	assign at_period = st_reg.channel_counter == st_reg.timer_period_reg;
	assign boundary = tick && (st_reg.run == RUN_GO) && at_period;
	assign fault_on = pwm && (st_reg.pin_a_fault_status || st_reg.pin_b_fault_status
		|| st_reg.comparator_fault_status);

	// Waveform from the shadow values; a full-duty compare overrides both alignment modes, and a fault still wins at the pin
	always_comb begin
		if (st_reg.scmp_active > st_reg.timer_period_reg) begin
			level = 1'b1;
		end else if (st_reg.channel_mode_field == MODE_CENTER) begin
			level = (st_reg.channel_counter >= st_reg.pcmp_active)
				&& (st_reg.channel_counter < st_reg.scmp_active);
		end else begin
			level = st_reg.channel_counter < st_reg.scmp_active;
		end
	end

	// ==========================================================
	// Next state
	always_comb begin
		st_next = st_reg;

		// Register writes; status bits are written here and then hardware sets win
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				REG_CON1: begin
					st_next.idle_halt_bit = reg_wdata_i[CON1_IDLE_BIT];
					st_next.time_base_select = reg_wdata_i[CON1_TSEL_LSB +: 3];
					st_next.comparator_fault_enable = reg_wdata_i[CON1_EN_CMP_BIT];
					st_next.pin_b_fault_enable = reg_wdata_i[CON1_EN_B_BIT];
					st_next.pin_a_fault_enable = reg_wdata_i[CON1_EN_A_BIT];
					st_next.comparator_fault_status = reg_wdata_i[CON1_ST_CMP_BIT];
					st_next.pin_b_fault_status = reg_wdata_i[CON1_ST_B_BIT];
					st_next.pin_a_fault_status = reg_wdata_i[CON1_ST_A_BIT];
					st_next.trigger_clear_select = reg_wdata_i[CON1_TRIGGER_CLEAR_SELECT_BIT];
					st_next.channel_mode_field = reg_wdata_i[CON1_MODE_LSB +: 3];
				end
				REG_CON2: begin
					st_next.fault_exit_select = reg_wdata_i[CON2_FLT_EXIT_BIT];
					st_next.fault_drive_level = reg_wdata_i[CON2_FLT_LEVEL_BIT];
					st_next.trigger_versus_sync_bit = reg_wdata_i[CON2_TRIG_BIT];
					st_next.sync_source_select = reg_wdata_i[CON2_SYNC_LSB +: 5];
				end
				REG_PCMP: st_next.primary_compare_reg = reg_wdata_i;
				REG_SCMP: st_next.secondary_compare_reg = reg_wdata_i;
				REG_PERIOD: st_next.timer_period_reg = reg_wdata_i;
				default: begin
				end
			endcase
		end

		// Counter run state; trigger mode holds the counter clear until an event
		unique case (st_reg.run)
			RUN_OFF: begin
				st_next.channel_counter = WORD_RESET;
				st_next.pcmp_active = st_reg.primary_compare_reg;
				st_next.scmp_active = st_reg.secondary_compare_reg;
				if (st_reg.channel_mode_field != MODE_OFF) begin
					st_next.run = (st_reg.trigger_versus_sync_bit
						&& (st_reg.sync_source_select != SYNC_NONE)) ? RUN_ARMED : RUN_GO;
				end
			end
			RUN_ARMED: begin
				if (st_reg.channel_mode_field == MODE_OFF) begin
					st_next.run = RUN_OFF;
				end else if (sync_event_i) begin
					st_next.run = RUN_GO;
				end
			end
			RUN_GO: begin
				if (st_reg.channel_mode_field == MODE_OFF) begin
					st_next.run = RUN_OFF;
					st_next.channel_counter = WORD_RESET;
				end else if (tick) begin
					if (st_reg.trigger_versus_sync_bit && st_reg.trigger_clear_select
						&& (st_reg.channel_counter == st_reg.secondary_compare_reg)) begin
						st_next.run = RUN_ARMED;
						st_next.channel_counter = WORD_RESET;
					end else if (self_sync && at_period) begin
						st_next.channel_counter = WORD_RESET;
					end else if ((st_reg.sync_source_select != SYNC_NONE)
						&& !st_reg.trigger_versus_sync_bit && !self_sync && sync_event_i) begin
						st_next.channel_counter = WORD_RESET;
					end else begin
						st_next.channel_counter = st_reg.channel_counter + 16'h0001;
					end
				end
			end
		endcase

		// Shadow duty values move when the period completes (the off state also copies them)
		if (boundary) begin
			st_next.pcmp_active = st_reg.primary_compare_reg;
			st_next.scmp_active = st_reg.secondary_compare_reg;
		end

		// Fault exit on a new period once the source has gone
		if (boundary && !st_reg.fault_exit_select) begin
			if (!flt.pin_a) st_next.pin_a_fault_status = 1'b0;
			if (!flt.pin_b) st_next.pin_b_fault_status = 1'b0;
			if (!flt.cmp) st_next.comparator_fault_status = 1'b0;
		end

		// Sources set status last so a same-cycle clear never loses an event
		if (pwm && st_reg.pin_a_fault_enable && flt.pin_a) begin
			st_next.pin_a_fault_status = 1'b1;
		end
		if (pwm && st_reg.pin_b_fault_enable && flt.pin_b) begin
			st_next.pin_b_fault_status = 1'b1;
		end
		if (pwm && st_reg.comparator_fault_enable && flt.cmp) begin
			st_next.comparator_fault_status = 1'b1;
		end

		// Output pin; compare modes outside PWM leave it low
		if (fault_on) begin
			st_next.out = st_reg.fault_drive_level;
		end else if (pwm && st_reg.run == RUN_GO) begin
			st_next.out = level;
		end else begin
			st_next.out = 1'b0;
		end

		// Read data stands for exactly one cycle after the strobe
		st_next.rdata = WORD_RESET;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				REG_CON1: st_next.rdata = {2'b00, st_reg.idle_halt_bit,
					st_reg.time_base_select, st_reg.comparator_fault_enable,
					st_reg.pin_b_fault_enable, st_reg.pin_a_fault_enable,
					st_reg.comparator_fault_status, st_reg.pin_b_fault_status,
					st_reg.pin_a_fault_status, st_reg.trigger_clear_select,
					st_reg.channel_mode_field};
				REG_CON2: st_next.rdata = {st_reg.fault_exit_select, st_reg.fault_drive_level,
					6'h00, st_reg.trigger_versus_sync_bit, st_reg.run == RUN_GO, 1'b0,
					st_reg.sync_source_select};
				REG_PCMP: st_next.rdata = st_reg.primary_compare_reg;
				REG_SCMP: st_next.rdata = st_reg.secondary_compare_reg;
				REG_PERIOD: st_next.rdata = st_reg.timer_period_reg;
				REG_COUNT: st_next.rdata = st_reg.channel_counter;
				default: st_next.rdata = WORD_RESET;
			endcase
		end
	end

	// ==========================================================
	// State register; clock enable low freezes everything
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st_reg <= '0;
			st_reg.time_base_select <= TSEL_RESET;
			st_reg.channel_mode_field <= MODE_RESET;
			st_reg.sync_source_select <= SYNC_RESET;
			st_reg.run <= RUN_OFF;
		end else if (ce_i) begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata_o = st_reg.rdata;
	assign compare_output_pin_o = st_reg.out;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_self_sync_wrap: assert property (ce_i && tick && st_reg.run == RUN_GO && self_sync
		&& at_period && st_reg.channel_mode_field != MODE_OFF
		|=> st_reg.channel_counter == 16'h0000)
		else $error("self synced counter did not restart at period match");

	a_duty_latch_now: assert property (ce_i && boundary
		|=> st_reg.pcmp_active == $past(st_reg.primary_compare_reg)
		&& st_reg.scmp_active == $past(st_reg.secondary_compare_reg))
		else $error("shadow duty not loaded at period boundary");

	a_duty_hold_mid: assert property (ce_i && st_reg.run == RUN_GO && !boundary
		|=> $stable(st_reg.scmp_active) && $stable(st_reg.pcmp_active))
		else $error("shadow duty changed inside a period");

	a_zero_duty_low: assert property (ce_i && pwm && !fault_on && st_reg.run == RUN_GO
		&& st_reg.scmp_active == 16'h0000 && st_reg.pcmp_active == 16'h0000
		&& st_reg.timer_period_reg == 16'h0000 |=> !compare_output_pin_o)
		else $error("zero duty output not low");

	a_full_duty_high: assert property (ce_i && pwm && !fault_on && st_reg.run == RUN_GO
		&& st_reg.scmp_active > st_reg.timer_period_reg |=> compare_output_pin_o)
		else $error("full duty output not high");

	a_fault_drive_lvl: assert property (ce_i && fault_on
		|=> compare_output_pin_o == $past(st_reg.fault_drive_level))
		else $error("fault output level wrong");

	a_fault_mode_gate: assert property (ce_i && !pwm && !reg_wr_i
		&& !st_reg.pin_a_fault_status |=> !st_reg.pin_a_fault_status)
		else $error("fault status set outside PWM modes");

	a_pin_b_fault_set: assert property (ce_i && pwm && st_reg.pin_b_fault_enable
		&& flt.pin_b |=> st_reg.pin_b_fault_status)
		else $error("pin B fault not flagged");

	a_idle_halt_cnt: assert property (ce_i && idle_mode_i && st_reg.idle_halt_bit
		&& st_reg.run == RUN_GO && st_reg.channel_mode_field != MODE_OFF
		|=> $stable(st_reg.channel_counter))
		else $error("counter moved while halted in idle");

	a_timer_tick_only: assert property (ce_i && st_reg.run == RUN_GO
		&& st_reg.time_base_select == TSEL_T2 && !timer_tick_i[1]
		&& st_reg.channel_mode_field != MODE_OFF |=> $stable(st_reg.channel_counter))
		else $error("counter moved without prescaler tick");
endmodule

//--- hw/ocpwm_pkg.sv
// Purpose: Shared constants and types of the output compare PWM unit.
// Assumes: 16-bit registers reached by word index over a plain port.
// Notes: Each offset, field position, reset value and code is named once here.
package ocpwm_pkg;

	// ==========================================================
	// Widths
	localparam int unsigned ADDR_W = 3;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned NUM_TIMERS = 5;

	// ==========================================================
	// Register indices
	localparam logic [ADDR_W-1:0] REG_CON1 = 3'h0;
	localparam logic [ADDR_W-1:0] REG_CON2 = 3'h1;
	localparam logic [ADDR_W-1:0] REG_PCMP = 3'h2;
	localparam logic [ADDR_W-1:0] REG_SCMP = 3'h3;
	localparam logic [ADDR_W-1:0] REG_PERIOD = 3'h4;
	localparam logic [ADDR_W-1:0] REG_COUNT = 3'h5;

	// ==========================================================
	// Field positions of control register one
	localparam int unsigned CON1_IDLE_BIT = 13;
	localparam int unsigned CON1_TSEL_LSB = 10;
	localparam int unsigned CON1_EN_CMP_BIT = 9;
	localparam int unsigned CON1_EN_B_BIT = 8;
	localparam int unsigned CON1_EN_A_BIT = 7;
	localparam int unsigned CON1_ST_CMP_BIT = 6;
	localparam int unsigned CON1_ST_B_BIT = 5;
	localparam int unsigned CON1_ST_A_BIT = 4;
	localparam int unsigned CON1_TRIGGER_CLEAR_SELECT_BIT = 3;
	localparam int unsigned CON1_MODE_LSB = 0;

	// ==========================================================
	// Field positions of control register two
	localparam int unsigned CON2_FLT_EXIT_BIT = 15;
	localparam int unsigned CON2_FLT_LEVEL_BIT = 14;
	localparam int unsigned CON2_TRIG_BIT = 7;
	localparam int unsigned CON2_TRIGSTAT_BIT = 6;
	localparam int unsigned CON2_SYNC_LSB = 0;

	// ==========================================================
	// Reset values
	localparam logic [2:0] MODE_RESET = 3'h0;
	localparam logic [2:0] TSEL_RESET = 3'h0;
	localparam logic [4:0] SYNC_RESET = 5'h0C;
	localparam logic [DATA_W-1:0] WORD_RESET = 16'h0000;

	// ==========================================================
	// Mode, time base and sync codes
	localparam logic [2:0] MODE_OFF = 3'h0;
	localparam logic [2:0] MODE_EDGE = 3'h6;
	localparam logic [2:0] MODE_CENTER = 3'h7;
	localparam logic [2:0] TSEL_T2 = 3'h0;
	localparam logic [2:0] TSEL_T3 = 3'h1;
	localparam logic [2:0] TSEL_T4 = 3'h2;
	localparam logic [2:0] TSEL_T5 = 3'h3;
	localparam logic [2:0] TSEL_T1 = 3'h4;
	localparam logic [2:0] TSEL_PCLK = 3'h7;
	localparam logic [4:0] SYNC_NONE = 5'h00;
	localparam logic [4:0] SYNC_SELF = 5'h1F;

	// ==========================================================
	// Counter run state
	typedef enum logic [2:0] {
		RUN_OFF = 3'b001,
		RUN_ARMED = 3'b010,
		RUN_GO = 3'b100
	} ocpwm_run_t;

endpackage

//--- hw/ocpwm_fault_if.sv
// Purpose: Carries raw and synchronised fault sources between the top and its syncer.
// Assumes: Raw sources are asynchronous to clk_i.
// Notes: Synced levels are safe for any logic in the clock domain.
`timescale 1ns/1ps
interface ocpwm_fault_if;
	logic pin_a_raw;
	logic pin_b_raw;
	logic cmp_raw;
	logic pin_a;
	logic pin_b;
	logic cmp;

	modport syncer (input pin_a_raw, input pin_b_raw, input cmp_raw,
		output pin_a, output pin_b, output cmp);
	modport user (output pin_a_raw, output pin_b_raw, output cmp_raw,
		input pin_a, input pin_b, input cmp);
endinterface

//--- hw/ocpwm_fault_sync.sv
// Purpose: Two-stage synchroniser for the three fault sources.
// Assumes: Sources are levels; pulses shorter than one clock may be missed.
// Notes: First stage feeds only the second stage; clock enable freezes both.
`timescale 1ns/1ps
module ocpwm_fault_sync (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	ocpwm_fault_if.syncer flt
);
	typedef struct packed {
		logic [2:0] meta;
		logic [2:0] sync;
	} ocpwm_sync_state_t;

	ocpwm_sync_state_t st_reg;
	ocpwm_sync_state_t st_next;

	// ==========================================================
	// Shift chain
	always_comb begin
		st_next = st_reg;
		st_next.meta = {flt.cmp_raw, flt.pin_b_raw, flt.pin_a_raw};
		st_next.sync = st_reg.meta;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st_reg <= '0;
		end else if (ce_i) begin
			st_reg <= st_next;
		end
	end

	// Synced levels only
	assign flt.pin_a = st_reg.sync[0];
	assign flt.pin_b = st_reg.sync[1];
	assign flt.cmp = st_reg.sync[2];
endmodule

//--- verification/ocpwm_load.sv
// Purpose: Load model on the PWM pin that tallies the cycles it is driven high.
// Assumes: Push-pull pin sampled on clk_i; the load never drives back.
// Notes: The bench takes tally differences over whole PWM periods.
`timescale 1ns/1ps
module ocpwm_load (
	input wire logic clk_i,
	input wire logic pin_i,
	output int high_cnt_o
);
	// ==========================================================
	// Tally
	// An unknown level is not counted, so it shows up as a duty error
	initial high_cnt_o = 0;
	always @(posedge clk_i) begin
		if (pin_i === 1'b1) high_cnt_o <= high_cnt_o + 1;
	end
endmodule

//--- verification/tb_top.sv
// Purpose: Self-checking bench for the output compare PWM unit.
// Assumes: One clock; fault sources are driven as slow levels.
// Notes: Duty is judged by high counts over whole periods, so phase does not matter.
`timescale 1ns/1ps
module tb_top;
	import ocpwm_pkg::*;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [ADDR_W-1:0] reg_addr_i = '0;
	logic [DATA_W-1:0] reg_wdata_i = '0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [DATA_W-1:0] reg_rdata_o;
	logic [NUM_TIMERS-1:0] timer_tick_i = '0;
	logic [NUM_TIMERS-1:0] tick_mask = '0;
	logic phase = 1'b0;
	logic idle_mode_i = 1'b0;
	logic ce = 1'b1;
	logic sync_ev = 1'b0;
	logic [2:0] src = 3'h0;
	logic [1:0] cmp_hi = 2'h0;
	logic pin;
	int high_cnt;
	int failures = 0;
	int total_checks = 0;
	localparam logic [15:0] BASE = {3'h0, TSEL_PCLK, 7'h00, MODE_EDGE};

	// ==========================================================
	// Design, load and stimulus sources
	ocpwm_top #(.CHANNEL_NUM(1)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .timer_tick_i(timer_tick_i),
		.idle_mode_i(idle_mode_i), .sync_event_i(sync_ev), .fault_pin_a_i(src[0]),
		.fault_pin_b_i(src[1]), .comparator_out_i({cmp_hi, src[2]}),
		.compare_output_pin_o(pin));
	ocpwm_load i_load (.clk_i(clk_i), .pin_i(pin), .high_cnt_o(high_cnt));
	always #5 clk_i = ~clk_i;
	// Prescaler ticks every other cycle, only on the bits under test
	always @(posedge clk_i) begin
		phase <= ~phase;
		timer_tick_i <= phase ? tick_mask : '0;
	end

	// ==========================================================
	// Shared tasks
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		@(negedge clk_i);
		d = reg_rdata_o;
		// Return on a rising edge so callers drive inputs there
		@(posedge clk_i);
	endtask
	// Disable first so the shadows reload when the mode is written again
	task automatic setup(input logic [15:0] c1, c2, pri, sec, per);
		wr(REG_CON1, 16'h0000);
		wr(REG_CON2, c2);
		wr(REG_PCMP, pri);
		wr(REG_SCMP, sec);
		wr(REG_PERIOD, per);
		wr(REG_CON1, c1);
		repeat (6) @(posedge clk_i);
	endtask
	task automatic measure(input int n, input logic [15:0] exp);
		int a;
		@(negedge clk_i);
		a = high_cnt;
		repeat (n) @(negedge clk_i);
		check(16'(high_cnt - a), exp);
		@(posedge clk_i);
	endtask
	task automatic conclude();
		if (failures == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_regs();
		logic [15:0] d;
		rd(REG_CON1, d);
		check(d, 16'h0000);
		wr(REG_CON1, 16'hC000);
		rd(REG_CON1, d);
		check(d, 16'h0000);
		wr(3'h6, 16'hFFFF);
		rd(3'h6, d);
		check(d, 16'h0000);
	endtask
	task automatic t_wave();
		logic [15:0] d;
		setup(BASE, 16'h001F, 16'h0000, 16'h0002, 16'h0003);
		measure(8, 16'h0004);
		repeat (4) begin
			rd(REG_COUNT, d);
			check(16'(d > 16'h0003), 16'h0000);
		end
		wr(REG_SCMP, 16'h0003);
		repeat (8) @(posedge clk_i);
		measure(8, 16'h0006);
		wr(REG_SCMP, 16'h0005);
		repeat (8) @(posedge clk_i);
		measure(8, 16'h0008);
		setup({3'h0, TSEL_PCLK, 7'h00, MODE_CENTER}, 16'h001F, 16'h1, 16'h3, 16'h3);
		measure(8, 16'h0004);
		setup(BASE, 16'h001F, 16'h0000, 16'h0000, 16'h0000);
		measure(8, 16'h0000);
	endtask
	task automatic t_tsel();
		logic [15:0] c1;
		logic [15:0] c2;
		for (int i = 0; i < 5; i++) begin
			tick_mask <= (i == 4) ? 5'h01 : 5'(2 << i);
			setup({3'h0, 3'(i), 7'h00, MODE_EDGE}, 16'h001F, 16'h0, 16'h2, 16'h3);
			measure(16, 16'h0008);
		end
		tick_mask <= 5'h1F;
		setup({3'h0, 3'h5, 7'h00, MODE_EDGE}, 16'h001F, 16'h0, 16'h2, 16'h3);
		rd(REG_COUNT, c1);
		rd(REG_COUNT, c2);
		check(c2, c1);
		tick_mask <= 5'h00;
	endtask
	task automatic t_idle();
		logic [15:0] c1;
		logic [15:0] c2;
		setup(BASE | 16'h2000, 16'h001F, 16'h0, 16'h2, 16'h00FF);
		idle_mode_i <= 1'b1;
		rd(REG_COUNT, c1);
		rd(REG_COUNT, c2);
		check(c2, c1);
		idle_mode_i <= 1'b0;
		rd(REG_COUNT, c1);
		rd(REG_COUNT, c2);
		check(16'(c1 === c2), 16'h0000);
		wr(REG_CON1, BASE);
		idle_mode_i <= 1'b1;
		rd(REG_COUNT, c1);
		rd(REG_COUNT, c2);
		check(16'(c1 === c2), 16'h0000);
		idle_mode_i <= 1'b0;
	endtask
	// Clock enable low freezes the counter, so the gap adds no counts
	task automatic t_ce();
		logic [15:0] c1;
		logic [15:0] c2;
		setup(BASE, 16'h001F, 16'h0, 16'h2, 16'h00FF);
		rd(REG_COUNT, c1);
		ce <= 1'b0;
		repeat (4) @(posedge clk_i);
		ce <= 1'b1;
		rd(REG_COUNT, c2);
		check(16'(c2 - c1), 16'h0003);
	endtask
	// Trigger mode holds the counter until one sync event arrives
	task automatic t_trig();
		logic [15:0] d;
		setup(BASE, 16'h008C, 16'h0, 16'h2, 16'h00FF);
		rd(REG_CON2, d);
		check(d, 16'h008C);
		sync_ev <= 1'b1;
		@(posedge clk_i);
		sync_ev <= 1'b0;
		repeat (4) @(posedge clk_i);
		rd(REG_CON2, d);
		check(d, 16'h00CC);
		rd(REG_COUNT, d);
		check(16'(d == 16'h0000), 16'h0000);
	endtask
	task automatic t_fault();
		logic [15:0] d;
		logic [15:0] en;
		// Software side is assumed to have the compare interrupt enabled; no IRQ here
		setup(BASE, 16'h401F, 16'h0, 16'h0, 16'h3);
		// Comparators of other channel groups must not reach this channel
		cmp_hi <= 2'h3;
		wr(REG_CON1, BASE | 16'h0380);
		repeat (6) @(posedge clk_i);
		measure(4, 16'h0000);
		cmp_hi <= 2'h0;
		wr(REG_CON1, BASE);
		for (int i = 0; i < 3; i++) begin
			en = 16'(1 << (7 + i));
			src <= 3'(1 << i);
			repeat (6) @(posedge clk_i);
			measure(4, 16'h0000);
			wr(REG_CON1, BASE | en);
			repeat (6) @(posedge clk_i);
			measure(4, 16'h0004);
			rd(REG_CON1, d);
			check(d, BASE | en | 16'(1 << (4 + i)));
			src <= 3'h0;
			repeat (12) @(posedge clk_i);
			rd(REG_CON1, d);
			check(d, BASE | en);
			measure(4, 16'h0000);
			wr(REG_CON1, BASE);
		end
		wr(REG_CON1, 16'h1F85);
		src <= 3'h7;
		repeat (6) @(posedge clk_i);
		rd(REG_CON1, d);
		check(d, 16'h1F85);
		src <= 3'h0;
		setup(BASE | 16'h0080, 16'hC01F, 16'h0, 16'h0, 16'h3);
		src <= 3'h1;
		repeat (6) @(posedge clk_i);
		src <= 3'h0;
		repeat (12) @(posedge clk_i);
		rd(REG_CON1, d);
		check(d, BASE | 16'h0090);
		wr(REG_CON1, BASE | 16'h0080);
		rd(REG_CON1, d);
		check(d, BASE | 16'h0080);
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_regs();
		t_wave();
		t_tsel();
		t_idle();
		t_ce();
		t_trig();
		t_fault();
		conclude();
	end
	// The tests need well under a thousand cycles; this limit only catches a hang
	initial begin
		repeat (20000) @(posedge clk_i);
		failures++;
		conclude();
	end
endmodule
